// ===== core/tcp_pkg.sv
// Purpose: Shared constants and types for the three-channel pulse-width modulator.
// Assumes: One clock domain; registers reached over a plain strobe port.
// Notes:   Offsets are byte addresses on the register port.
`default_nettype none
package tcp_pkg;
  localparam int          TCP_NUM_CH       = 3;
  localparam int          TCP_CNT_W        = 8;
  localparam int          TCP_ADDR_W       = 13;
  localparam logic [12:0] TCP_ADDR_DUTY0   = 13'h1fb0;
  localparam logic [12:0] TCP_ADDR_DUTY1   = 13'h1fb2;
  localparam logic [12:0] TCP_ADDR_DUTY2   = 13'h1fb4;
  localparam logic [12:0] TCP_ADDR_CTRL    = 13'h1fb6;
  localparam int          TCP_BIT_HALF     = 0;
  localparam int          TCP_BIT_QUARTER  = 1;
  localparam int          TCP_BIT_SHUTDOWN = 7;
  localparam logic [7:0]  TCP_CTRL_RESET   = 8'h7c;
  localparam logic [7:0]  TCP_CTRL_RSVD    = 8'h7c;
  localparam logic [7:0]  TCP_DUTY_RESET   = 8'h00;
  // Clock periods per counter step before prescaling: one step is two clocks.
  localparam int          TCP_BASE_DIV     = 2;
  localparam logic [2:0]  TCP_STEP_OFF     = 3'h1;
  localparam logic [2:0]  TCP_STEP_HALF    = 3'h3;
  localparam logic [2:0]  TCP_STEP_QUARTER = 3'h7;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } tcp_bus_req_t;

  typedef struct packed {
    logic shutdown;
    logic quarter_rate_select;
    logic half_rate_select;
  } tcp_ctrl_t;
endpackage : tcp_pkg
`default_nettype wire

// ===== core/tcp_prescaler.sv
// Purpose: Shared prescaler that paces the counter of the modulator.
// Assumes: Select bits come straight from the control register.
// Notes:   A step pulse is raised once per 2, 4 or 8 clocks.
`default_nettype none
module tcp_prescaler
  import tcp_pkg::*;
(
  // Clock and reset
  input  wire logic      core_clk,
  input  wire logic      resetn,
  // Control
  input  wire tcp_ctrl_t ctrl,
  // Step output
  output logic           step
);
  logic [2:0] div_cnt;
  logic [2:0] limit;

  // The quarter select dominates, so the half select is ignored beside it.
  always_comb begin
    if (ctrl.quarter_rate_select) begin
      limit = TCP_STEP_QUARTER; // [RULE10]
    end else if (ctrl.half_rate_select) begin
      limit = TCP_STEP_HALF; // [RULE9]
    end else begin
      limit = TCP_STEP_OFF; // [RULE8]
    end
  end

  // Held at zero while shut down so the divider restarts cleanly.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 3'h0;
    end else if (ctrl.shutdown) begin
      div_cnt <= 3'h0; // [RULE16]
    end else if (div_cnt >= limit) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  assign step = !ctrl.shutdown && (div_cnt >= limit); // [RULE15]

  property p_step_spacing_off;
    @(posedge core_clk) disable iff (!resetn)
    (step && !ctrl.quarter_rate_select && !ctrl.half_rate_select && !ctrl.shutdown)
      ##1 (!ctrl.quarter_rate_select && !ctrl.half_rate_select && !ctrl.shutdown)
      |-> !step ##1 (step || $changed(ctrl));
  endproperty
  a_step_spacing_off: assert property (p_step_spacing_off) // [RULE8]
    else $error("Step spacing wrong with prescaler off.");

  property p_step_spacing_quarter;
    @(posedge core_clk) disable iff (!resetn)
    (step && ctrl.quarter_rate_select && !ctrl.shutdown && $stable(ctrl))
      |-> ##1 (!step || !ctrl.quarter_rate_select || ctrl.shutdown)[*7]
      ##1 (step || $changed(ctrl) || !ctrl.quarter_rate_select || ctrl.shutdown);
  endproperty
  a_step_spacing_quarter: assert property (p_step_spacing_quarter) // [RULE10]
    else $error("Step spacing wrong with quarter rate.");
endmodule : tcp_prescaler
`default_nettype wire

// ===== core/tcp_channel.sv
// Purpose: One modulator channel: duty buffer, comparator and set/reset output.
// Assumes: Counter and step pulse are shared by all channels.
// Notes:   Output is registered.
`default_nettype none
module tcp_channel
  import tcp_pkg::*;
#(
  parameter int CNT_W = TCP_CNT_W
)
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // Shared timing
  input  wire logic             step,
  input  wire logic [CNT_W-1:0] count,
  input  wire logic             shutdown,
  // Software duty value
  input  wire logic [CNT_W-1:0] pwm_duty_value,
  // Pulse output
  output logic                  pulse_out
);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  logic [CNT_W-1:0] duty_buf;
  logic             wrap;
  logic [CNT_W-1:0] next_buf;

  assign wrap     = step && (count == CNT_MAX);
  assign next_buf = pwm_duty_value;

  // The buffer changes only at the wrap, so mid-period writes wait a period.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      duty_buf <= TCP_DUTY_RESET;
    end else if (wrap) begin
      duty_buf <= next_buf; // [RULE2] [RULE3]
    end
  end

  // Set at wrap unless the new duty is zero; clear on match.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_out <= 1'b0;
    end else if (shutdown) begin
      pulse_out <= 1'b0; // [RULE16]
    end else if (wrap) begin
      pulse_out <= (next_buf != '0); // [RULE4] [RULE6]
    end else if (step && (CNT_W'(count + 1'b1) == duty_buf)) begin
      pulse_out <= 1'b0; // [RULE5] [RULE7] [RULE12]
    end
  end

  property p_zero_duty_low;
    @(posedge core_clk) disable iff (!resetn)
    (duty_buf == '0) && !wrap |=> !pulse_out;
  endproperty
  a_zero_duty_low: assert property (p_zero_duty_low) // [RULE6]
    else $error("Output high with zero duty.");

  property p_high_at_wrap;
    @(posedge core_clk) disable iff (!resetn)
    wrap && !shutdown && (pwm_duty_value != '0) |=> pulse_out && (count == '0);
  endproperty
  a_high_at_wrap: assert property (p_high_at_wrap) // [RULE4]
    else $error("Output not high after wrap.");

  property p_low_on_match;
    @(posedge core_clk) disable iff (!resetn)
    pulse_out && !wrap && (count == duty_buf) |-> !pulse_out || shutdown;
  endproperty
  a_low_on_match: assert property (p_low_on_match) // [RULE5]
    else $error("Output high past duty match.");

  property p_buffer_holds;
    @(posedge core_clk) disable iff (!resetn)
    !wrap |=> $stable(duty_buf);
  endproperty
  a_buffer_holds: assert property (p_buffer_holds) // [RULE3]
    else $error("Duty buffer changed outside wrap.");
endmodule : tcp_channel
`default_nettype wire

// ===== core/tcp_pwm.sv
// Purpose: Top of the three-channel pulse-width modulator with its registers.
// Assumes: Register port is synchronous; read data appear the cycle after a read.
// Notes:   Duty writes are buffered and take effect at the next counter wrap.
// Function
// [RULE1] Three outputs share one eight-bit counter and prescaler; each has buffer, comparator.
// [RULE2] Duty value copied into channel buffer when counter wraps from maximum to zero.
// [RULE3] Duty writes any time; comparator uses old buffer until the period ends.
// [RULE4] Every wrap to zero drives each channel output high unless its new duty is zero.
// [RULE5] Output stays high until counter equals buffered duty, then low until wrap.
// [RULE6] Buffered duty of zero keeps the output low for the whole period.
// [RULE7] Duty of all ones gives high for all but one count step.
// [RULE8] Both select bits clear: prescaler bypassed, period 512 state times.
// [RULE9] Low select bit only: divide-by-two, period 1,024 state times.
// [RULE10] High select bit set: divide-by-four, low bit ignored, period 2,048.
// [RULE11] Select bits sit at bits zero and one of the control register.
// [RULE12] High time equals duty times 2, 4 or 8 clock periods.
// [RULE13] Generator control bit seven is cleared by reset; generator active.
// [RULE14] Software may set bit seven to shut the generator down when unused.
// [RULE15] Counter advances once per two prescaled clock periods; 256 counts per period.
// [RULE16] While shut down, counter frozen and all three outputs held low.
`default_nettype none
module tcp_pwm
  import tcp_pkg::*;
#(
  parameter int NUM_CH = TCP_NUM_CH,
  parameter int CNT_W  = TCP_CNT_W
)
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // Register port
  input  wire logic [12:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  // Pulse outputs
  output logic [NUM_CH-1:0]      pulse_out
);
  tcp_bus_req_t     req;
  tcp_ctrl_t        ctrl;
  logic [7:0]       ctrl_reg;
  logic [CNT_W-1:0] duty [NUM_CH];
  logic [CNT_W-1:0] count;
  logic             step;
  logic [7:0]       next_rdata;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Reset value keeps the shutdown bit clear so the generator runs.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= TCP_CTRL_RESET; // [RULE13]
    end else if (req.wr && req.addr == TCP_ADDR_CTRL) begin
      // Reserved bits keep their fixed pattern; software cannot alter them.
      ctrl_reg <= (req.wdata & ~TCP_CTRL_RSVD) | TCP_CTRL_RSVD; // [RULE14]
    end
  end

  assign ctrl = '{shutdown:            ctrl_reg[TCP_BIT_SHUTDOWN],
                  quarter_rate_select: ctrl_reg[TCP_BIT_QUARTER], // [RULE11]
                  half_rate_select:    ctrl_reg[TCP_BIT_HALF]}; // [RULE11]

  // Duty registers, one per channel, each at its own byte offset.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_duty
    localparam logic [12:0] OFFS = TCP_ADDR_DUTY0 + 13'(2 * i);
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        duty[i] <= TCP_DUTY_RESET;
      end else if (req.wr && req.addr == OFFS) begin
        duty[i] <= req.wdata[CNT_W-1:0]; // [RULE3]
      end
    end

    tcp_channel #(.CNT_W(CNT_W)) u_channel (
      .core_clk       (core_clk),
      .resetn         (resetn),
      .step           (step),
      .count          (count),
      .shutdown       (ctrl.shutdown),
      .pwm_duty_value (duty[i]),
      .pulse_out      (pulse_out[i])
    ); // [RULE1]
  end

  tcp_prescaler u_prescaler (
    .core_clk (core_clk),
    .resetn   (resetn),
    .ctrl     (ctrl),
    .step     (step)
  ); // [RULE1]

  // One shared counter; the wrap from all ones back to zero is natural overflow.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (step) begin
      count <= count + 1'b1; // [RULE15] [RULE16]
    end
  end

  // Unmapped addresses read as zero; narrower duty data sits low.
  always_comb begin
    next_rdata = 8'h00;
    case (req.addr)
      TCP_ADDR_DUTY0: next_rdata = 8'(duty[0]);
      TCP_ADDR_DUTY1: next_rdata = 8'(duty[1]);
      TCP_ADDR_DUTY2: next_rdata = 8'(duty[2]);
      TCP_ADDR_CTRL:  next_rdata = ctrl_reg;
      default:        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  property p_frozen_when_off;
    @(posedge core_clk) disable iff (!resetn)
    ctrl.shutdown && $past(ctrl.shutdown) |-> $stable(count) && (pulse_out == '0);
  endproperty
  a_frozen_when_off: assert property (p_frozen_when_off) // [RULE16]
    else $error("Counter moved or output high while shut down.");

  property p_select_bits;
    @(posedge core_clk) disable iff (!resetn)
    req.wr && req.addr == TCP_ADDR_CTRL |=>
      ctrl.half_rate_select == $past(req.wdata[0])
      && ctrl.quarter_rate_select == $past(req.wdata[1]);
  endproperty
  a_select_bits: assert property (p_select_bits) // [RULE11]
    else $error("Select bits not at positions zero and one.");

  property p_count_rate_off;
    @(posedge core_clk) disable iff (!resetn)
    $past(resetn) && $past(resetn, 2)
      && ctrl_reg == TCP_CTRL_RESET && $past(ctrl_reg) == TCP_CTRL_RESET
      && $past(ctrl_reg, 2) == TCP_CTRL_RESET
      |-> count != $past(count, 2) && count == 8'($past(count, 2) + 8'h01);
  endproperty
  a_count_rate_off: assert property (p_count_rate_off) // [RULE8]
    else $error("Counter rate wrong with prescaler off.");

  // Full duty may only drop at the last step of the period, never before it.
  logic [CNT_W-1:0] duty2_probe;
  assign duty2_probe = g_duty[2].u_channel.duty_buf;

  property p_full_duty;
    @(posedge core_clk) disable iff (!resetn)
    step && count == 8'hfd && !ctrl.shutdown && pulse_out[2]
      && duty2_probe == 8'hff |=> pulse_out[2];
  endproperty
  a_full_duty: assert property (p_full_duty) // [RULE7]
    else $error("Full duty dropped early.");

  property p_read_latency;
    @(posedge core_clk) disable iff (!resetn)
    req.rd && req.addr == TCP_ADDR_CTRL |=> reg_rdata == $past(ctrl_reg);
  endproperty
  a_read_latency: assert property (p_read_latency) // [RULE13]
    else $error("Control read data wrong.");
endmodule : tcp_pwm
`default_nettype wire

// ===== verification/tcp_load_model.sv
// Purpose: Load model that watches the three pulse outputs as a driver stage would.
// Assumes: Outputs are registered levels sampled on the core clock.
// Notes:   Reports the last period, the last high time and a count of rising edges.
`default_nettype none
module tcp_load_model (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // Pulse inputs
  input  wire logic [2:0]       pulse,
  // Measurements
  output logic      [2:0][15:0] period,
  output logic      [2:0][15:0] high,
  output logic      [2:0][15:0] rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0]      now;
  logic [2:0][15:0] last_rise;
  logic [2:0]       prev;

  // Edges are timed in clock cycles so the figures read directly as state counts.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      now       <= 16'h0000;
      last_rise <= '0;
      prev      <= 3'h0;
      period    <= '0;
      high      <= '0;
      rises     <= '0;
    end else begin
      now  <= now + 16'h0001;
      prev <= pulse;
      for (int i = 0; i < 3; i++) begin
        if (pulse[i] && !prev[i]) begin
          period[i]    <= now - last_rise[i];
          last_rise[i] <= now;
          rises[i]     <= rises[i] + 16'h0001;
        end
        if (!pulse[i] && prev[i]) begin
          high[i] <= now - last_rise[i];
        end
      end
    end
  end
endmodule : tcp_load_model
`default_nettype wire

// ===== verification/tb_tcp_pwm.sv
// Purpose: Self-checking bench for the three-channel pulse-width modulator.
// Assumes: Register port answers reads in the following cycle.
// Notes:   Each prescaler mode runs three periods so the last one is whole.
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module tb_tcp_pwm
  import tcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             core_clk = 1'b0;
  logic             resetn   = 1'b0;
  logic [12:0]      reg_addr = 13'h0000;
  logic [7:0]       reg_wdata = 8'h00;
  logic             reg_wr   = 1'b0;
  logic             reg_rd   = 1'b0;
  logic [7:0]       reg_rdata;
  logic [2:0]       pulse_out;
  logic [2:0][15:0] period;
  logic [2:0][15:0] high;
  logic [2:0][15:0] rises;
  logic [7:0]       d;
  logic [15:0]      r;
  int               mismatches = 0;
  int               n_checks = 0;
  int               cyc = 0;
  int               step;

  always #50 core_clk = ~core_clk;

  tcp_pwm u_tcp_pwm (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pulse_out(pulse_out));
  tcp_load_model u_tcp_load_model (.core_clk(core_clk), .resetn(resetn),
    .pulse(pulse_out), .period(period), .high(high), .rises(rises));

  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [12:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // The tests need about 23000 cycles; the ceiling leaves a wide margin.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    rd(TCP_ADDR_CTRL, d);
    `CHK("ctrl reset", 8'h7c, d);
    rd(TCP_ADDR_DUTY1, d);
    `CHK("duty1 reset", 8'h00, d);
    wr(13'h1fb8, 8'h5a);
    rd(13'h1fb8, d);
    `CHK("unmapped", 8'h00, d);
    wr(TCP_ADDR_DUTY1, 8'ha5);
    rd(TCP_ADDR_DUTY1, d);
    `CHK("duty1 rw", 8'ha5, d);
    $display("test registers done");

    wr(TCP_ADDR_DUTY0, 8'h02);
    wr(TCP_ADDR_DUTY1, 8'h8a);
    wr(TCP_ADDR_DUTY2, 8'hff);
    for (int m = 0; m < 4; m++) begin
      step = (m == 0) ? 2 : (m == 1) ? 4 : 8;
      wr(TCP_ADDR_CTRL, 8'h7c | 8'(m));
      repeat (3 * 256 * step) @(posedge core_clk);
      `CHK("period0", 16'(256 * step), period[0]);
      `CHK("period2", 16'(256 * step), period[2]);
      `CHK("high0", 16'(2 * step), high[0]);
      `CHK("high1", 16'(138 * step), high[1]);
      `CHK("high2", 16'(255 * step), high[2]);
    end
    $display("test prescaler done");

    wr(TCP_ADDR_CTRL, 8'h7c);
    wr(TCP_ADDR_DUTY0, 8'h00);
    repeat (1024) @(posedge core_clk);
    r = rises[0];
    repeat (600) @(posedge core_clk);
    `CHK("zero rises", r, rises[0]);
    `CHK("zero level", 1'b0, pulse_out[0]);
    $display("test zero duty done");

    // A long old pulse lets the new value land while the output is still high.
    wr(TCP_ADDR_DUTY0, 8'h20);
    repeat (1024) @(posedge core_clk);
    r = rises[0];
    for (int k = 0; k < 600 && rises[0] == r; k++) @(posedge core_clk);
    wr(TCP_ADDR_DUTY0, 8'h10);
    repeat (100) @(posedge core_clk);
    `CHK("old duty", 16'd64, high[0]);
    repeat (1024) @(posedge core_clk);
    `CHK("new duty", 16'd32, high[0]);
    $display("test buffered duty done");

    wr(TCP_ADDR_CTRL, 8'hfc);
    repeat (2) @(posedge core_clk);
    r = rises[1];
    `CHK("off level", 3'h0, pulse_out);
    repeat (600) @(posedge core_clk);
    `CHK("off rises", r, rises[1]);
    `CHK("off level2", 3'h0, pulse_out);
    rd(TCP_ADDR_CTRL, d);
    `CHK("ctrl off", 8'hfc, d);
    wr(TCP_ADDR_CTRL, 8'h00);
    rd(TCP_ADDR_CTRL, d);
    `CHK("ctrl rsvd", 8'h7c, d);
    repeat (1100) @(posedge core_clk);
    `CHK("restart", 16'd512, period[1]);
    `CHK("restart rises", 1'b1, (rises[1] - r) >= 16'd2);
    $display("test shutdown done");
    end_of_test();
  end
endmodule : tb_tcp_pwm
`default_nettype wire
